//--- rtl/ext_irq_detect.sv
// External interrupt detector: pin synchronisers, falling-edge latch, level option
`timescale 1ns/1ps
`default_nettype none
module ext_irq_detect (
  input  wire logic i_sys_clk,
  input  wire logic i_rst,
  ext_req_if.det    bus
);
  localparam int N = irq_prio_pkg::EXT_LINES;

  logic [N-1:0] raw;
  logic [N-1:0] en;
  logic [N-1:0] low;
  logic [N-1:0] fall;
  logic         latch_reg;
  logic         request_reg;
  logic         line_high_reg;

  assign raw = {bus.irq_pin_n, bus.pb_pins};
  // Port B lines count only while their pull-up is on; the pin always counts
  assign en  = {1'b1, bus.pb_pullup_en};

  // Two flops per line before anything looks at it, then an edge detector
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_line
      logic meta_reg;
      logic sync_reg;
      logic prev_low_reg;
      always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
          meta_reg     <= 1'b1;
          sync_reg     <= 1'b1;
          prev_low_reg <= 1'b0;
        end else begin
          meta_reg     <= raw[g];
          sync_reg     <= meta_reg;
          prev_low_reg <= low[g];
        end
      end
      assign low[g]  = ~sync_reg & en[g];
      assign fall[g] = low[g] & ~prev_low_reg;
    end
  endgenerate

  // Latch one falling edge; a new edge beats a clear in the same cycle
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      latch_reg <= 1'b0;
    end else if (|fall) begin
      latch_reg <= 1'b1;
    end else if (bus.latch_clr) begin
      latch_reg <= 1'b0;
    end
  end

  // Port B follows the same trigger choice as the pin
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      request_reg   <= 1'b0;
      line_high_reg <= 1'b1;
    end else begin
      request_reg   <= (latch_reg & ~bus.latch_clr) | (|fall) | (bus.level_mode & |low);
      line_high_reg <= ~|low;
    end
  end

  assign bus.request   = request_reg;
  assign bus.line_high = line_high_reg;
endmodule
`default_nettype wire

//--- rtl/ext_req_if.sv
// Interface joining the external request detector to the prioritizer core
`timescale 1ns/1ps
`default_nettype none
interface ext_req_if;
  logic       irq_pin_n;
  logic [7:0] pb_pins;
  logic [7:0] pb_pullup_en;
  logic       level_mode;
  logic       latch_clr;
  logic       request;
  logic       line_high;

  modport det (input irq_pin_n, pb_pins, pb_pullup_en, level_mode, latch_clr,
               output request, line_high);
  modport ctl (output irq_pin_n, pb_pins, pb_pullup_en, level_mode, latch_clr,
               input request, line_high);
endinterface
`default_nettype wire

//--- rtl/irq_prio_pkg.sv
// Constants shared by the interrupt prioritizer and its external request detector
package irq_prio_pkg;

  // Service routine vector pairs, high byte address of each pair
  localparam logic [15:0] VEC_RESET = 16'h3FFE;
  localparam logic [15:0] VEC_TRAP  = 16'h3FFC;
  localparam logic [15:0] VEC_EXT   = 16'h3FFA;
  localparam logic [15:0] VEC_TIMER = 16'h3FF8;
  localparam logic [15:0] VEC_SCI   = 16'h3FF6;
  localparam logic [15:0] VEC_SPI   = 16'h3FF4;

  // Source codes reported with each vector, equal to the fixed priority
  localparam logic [2:0] SRC_NONE  = 3'h0;
  localparam logic [2:0] SRC_RESET = 3'h1;
  localparam logic [2:0] SRC_EXT   = 3'h2;
  localparam logic [2:0] SRC_TIMER = 3'h3;
  localparam logic [2:0] SRC_SCI   = 3'h4;
  localparam logic [2:0] SRC_SPI   = 3'h5;
  localparam logic [2:0] SRC_TRAP  = 3'h7;

  // Bytes moved per stacking or unstacking sequence
  localparam logic [2:0] STACK_BYTES = 3'h5;

  // Register map of the software port
  localparam logic [3:0] ADDR_CTRL    = 4'h0;
  localparam logic [3:0] ADDR_STATUS  = 4'h1;
  localparam logic [3:0] ADDR_VEC_LO  = 4'h2;
  localparam logic [3:0] ADDR_VEC_HI  = 4'h3;

  // Control register fields and value after reset (mask set)
  localparam int         CTRL_MASK_BIT   = 0;
  localparam int         CTRL_LEVEL_BIT  = 1;
  localparam int         CTRL_COMPAT_BIT = 2;
  localparam logic [7:0] CTRL_RESET      = 8'h01;

  // External inputs: eight port B lines plus the interrupt pin on top
  localparam int EXT_LINES = 9;

  typedef enum logic [1:0] {ST_RUN, ST_PUSH, ST_VECTOR, ST_POP} seq_state_e;

endpackage

//--- rtl/mcu_interrupt_prioritizer.sv
// Interrupt arbitration, stacking control and vectoring for an 8-bit core
// Operation
// - Accept external, timer, async serial, sync serial sources plus the software trap.
// - Taking an interrupt pushes registers and sets the global mask bit.
// - Return from trap restores stacked registers and resumes normal processing.
// - Hardware requests wait for the executing instruction to complete.
// - At completion, take a request only if unmasked and locally enabled.
// - Global mask set blocks all maskable sources; clearing it re-enables them.
// - Fixed priority: reset, external, timer, async serial, sync serial.
// - External request wins over timer or serial requests pending together.
// - Software trap executes regardless of the global mask bit.
// - Unmasked trap follows requests pending at its fetch, precedes later ones.
// - Software trap vectors through the pair at 3FFC.
// - External request latched on falling pin edge, synchronised, vectored at 3FFA.
// - Each port B pin with pull-up enabled is an extra external source.
// - Port B inputs use the same edge or edge-level selection as the pin.
// - Line-level branch tests see port B inputs exactly like the pin.
// - Trigger choice from software option bit or mask option bit by mode.
// - External latch clears early in service so one further pulse is kept.
// - Three timer flags, each enabled, share one timer vector at 3FF8.
// - Five async serial flags under four enables share one vector at 3FF6.
// - Two sync serial flags under one enable share one vector at 3FF4.
// - Reset aborts the instruction, initialises control bits, loads 3FFE vector.
`timescale 1ns/1ps
`default_nettype none
module mcu_interrupt_prioritizer (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  // External pins
  input  wire logic        i_irq_pin_n,
  input  wire logic [7:0]  i_pb_pins,
  input  wire logic [7:0]  i_pb_pullup_en,
  input  wire logic        i_mask_option_level,
  // Peripheral flag sources
  input  wire logic [2:0]  i_timer_flags,
  input  wire logic [2:0]  i_timer_irq_en,
  input  wire logic [4:0]  i_async_flags,
  input  wire logic [3:0]  i_async_irq_en,
  input  wire logic [1:0]  i_sync_flags,
  input  wire logic        i_sync_irq_enable,
  // Instruction sequencer
  input  wire logic        i_fetch,
  input  wire logic        i_instr_done,
  input  wire logic        i_instr_is_trap,
  input  wire logic        i_rti_exec,
  input  wire logic        i_stacked_mask,
  input  wire logic        i_reset_req,
  output logic             o_abort,
  output logic             o_stack_push,
  output logic             o_stack_pop,
  output logic [2:0]       o_stack_index,
  output logic             o_vector_valid,
  output logic [15:0]      o_vector_addr,
  output logic [2:0]       o_vector_source,
  output logic             o_resume,
  output logic             o_global_mask,
  output logic             o_line_high,
  // Software register port
  input  wire logic [3:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic [7:0]       o_rdata
);

  ext_req_if ext ();

  // Pin-facing detection lives in its own module behind the interface
  ext_irq_detect u_detect (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .bus       (ext.det)
  );

  irq_prio_pkg::seq_state_e state_reg;
  logic [2:0]  count_reg;
  logic [7:0]  ctrl_reg;
  logic        mask_reg;
  logic        opt_meta_reg;
  logic        opt_sync_reg;
  logic [3:0]  hw_at_fetch_reg;
  logic        trap_deferred_reg;
  logic        rti_seen_reg;
  logic [15:0] pend_vec_reg;
  logic [2:0]  pend_src_reg;
  logic        clr_ext_reg;
  logic        level_mode;
  logic        ext_req;
  logic        timer_req;
  logic        async_req;
  logic        sync_req;
  logic [3:0]  hw_now;
  logic        hw_take;
  logic        trap_take;
  logic        take;
  logic [15:0] sel_vec;
  logic [2:0]  sel_src;
  logic        rst_any;

  assign rst_any = i_rst | i_reset_req;

  // Mask option strap comes from outside, so it is synchronised first
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      opt_meta_reg <= 1'b0;
      opt_sync_reg <= 1'b0;
    end else begin
      opt_meta_reg <= i_mask_option_level;
      opt_sync_reg <= opt_meta_reg;
    end
  end

  // Trigger sensitivity: compatibility bit chooses software or mask option
  assign level_mode = ctrl_reg[irq_prio_pkg::CTRL_COMPAT_BIT] ? opt_sync_reg
                    : ctrl_reg[irq_prio_pkg::CTRL_LEVEL_BIT];

  assign ext.irq_pin_n    = i_irq_pin_n;
  assign ext.pb_pins      = i_pb_pins;
  assign ext.pb_pullup_en = i_pb_pullup_en;
  assign ext.level_mode   = level_mode;
  assign ext.latch_clr    = clr_ext_reg;

  // Source requests; each peripheral flag only counts with its enable
  assign ext_req   = ext.request & ~clr_ext_reg;
  assign timer_req = |(i_timer_flags & i_timer_irq_en);
  // Receive-full and overrun share the receive enable
  assign async_req = (i_async_flags[0] & i_async_irq_en[0])
                   | (i_async_flags[1] & i_async_irq_en[1])
                   | (|i_async_flags[3:2] & i_async_irq_en[2])
                   | (i_async_flags[4] & i_async_irq_en[3]);
  assign sync_req  = |i_sync_flags & i_sync_irq_enable;
  assign hw_now    = {sync_req, async_req, timer_req, ext_req};

  // Decide at an instruction boundary only; nothing is checked mid-instruction
  always_comb begin
    hw_take   = 1'b0;
    trap_take = 1'b0;
    sel_vec   = irq_prio_pkg::VEC_TRAP;
    sel_src   = irq_prio_pkg::SRC_TRAP;
    if (state_reg == irq_prio_pkg::ST_RUN && i_instr_done) begin
      if (trap_deferred_reg && rti_seen_reg) begin
        trap_take = 1'b1;
      end else if (!mask_reg && |hw_now
                   && (!i_instr_is_trap || |(hw_now & hw_at_fetch_reg))) begin
        hw_take = 1'b1;
      end else if (i_instr_is_trap) begin
        trap_take = 1'b1;
      end
    end
    // Fixed priority encoder, external first
    if (hw_take) begin
      if (ext_req) begin
        sel_vec = irq_prio_pkg::VEC_EXT;
        sel_src = irq_prio_pkg::SRC_EXT;
      end else if (timer_req) begin
        sel_vec = irq_prio_pkg::VEC_TIMER;
        sel_src = irq_prio_pkg::SRC_TIMER;
      end else if (async_req) begin
        sel_vec = irq_prio_pkg::VEC_SCI;
        sel_src = irq_prio_pkg::SRC_SCI;
      end else begin
        sel_vec = irq_prio_pkg::VEC_SPI;
        sel_src = irq_prio_pkg::SRC_SPI;
      end
    end else if (trap_take) begin
      sel_vec = irq_prio_pkg::VEC_TRAP;
      sel_src = irq_prio_pkg::SRC_TRAP;
    end
  end

  assign take = hw_take | trap_take;

  // Snapshot of hardware requests at each fetch, for trap ordering
  always_ff @(posedge i_sys_clk) begin
    if (rst_any) begin
      hw_at_fetch_reg <= 4'h0;
    end else if (i_fetch) begin
      hw_at_fetch_reg <= hw_now;
    end
  end

  // A trap that yielded to older requests waits for their return
  always_ff @(posedge i_sys_clk) begin
    if (rst_any) begin
      trap_deferred_reg <= 1'b0;
      rti_seen_reg      <= 1'b0;
    end else begin
      if (hw_take && i_instr_is_trap) begin
        trap_deferred_reg <= 1'b1;
      end else if (trap_take) begin
        trap_deferred_reg <= 1'b0;
      end
      if (state_reg == irq_prio_pkg::ST_POP && count_reg == 3'h1) begin
        rti_seen_reg <= 1'b1;
      end else if (take) begin
        rti_seen_reg <= 1'b0;
      end
    end
  end

  // Stacking sequencer: push five bytes, present vector, or pop on return
  always_ff @(posedge i_sys_clk) begin
    if (rst_any) begin
      state_reg    <= irq_prio_pkg::ST_RUN;
      count_reg    <= 3'h0;
      pend_vec_reg <= irq_prio_pkg::VEC_RESET;
      pend_src_reg <= irq_prio_pkg::SRC_NONE;
    end else begin
      case (state_reg)
        irq_prio_pkg::ST_RUN: begin
          if (take) begin
            state_reg    <= irq_prio_pkg::ST_PUSH;
            count_reg    <= irq_prio_pkg::STACK_BYTES;
            pend_vec_reg <= sel_vec;
            pend_src_reg <= sel_src;
          end else if (i_rti_exec) begin
            state_reg <= irq_prio_pkg::ST_POP;
            count_reg <= irq_prio_pkg::STACK_BYTES;
          end
        end
        irq_prio_pkg::ST_PUSH: begin
          count_reg <= count_reg - 3'h1;
          if (count_reg == 3'h1) begin
            state_reg <= irq_prio_pkg::ST_VECTOR;
          end
        end
        irq_prio_pkg::ST_VECTOR: begin
          state_reg <= irq_prio_pkg::ST_RUN;
        end
        irq_prio_pkg::ST_POP: begin
          count_reg <= count_reg - 3'h1;
          if (count_reg == 3'h1) begin
            state_reg <= irq_prio_pkg::ST_RUN;
          end
        end
        default: begin
          state_reg <= irq_prio_pkg::ST_RUN;
        end
      endcase
    end
  end

  // Clear the external latch as the external vector is handed out, so a
  // second pulse arriving during the routine is held for later
  always_ff @(posedge i_sys_clk) begin
    if (rst_any) begin
      clr_ext_reg <= 1'b0;
    end else begin
      clr_ext_reg <= (state_reg == irq_prio_pkg::ST_PUSH) && (count_reg == 3'h1)
                     && (pend_src_reg == irq_prio_pkg::SRC_EXT);
    end
  end

  // Global mask: reset and vectoring set it, return restores, software writes
  always_ff @(posedge i_sys_clk) begin
    if (rst_any) begin
      mask_reg <= irq_prio_pkg::CTRL_RESET[irq_prio_pkg::CTRL_MASK_BIT];
    end else if (state_reg == irq_prio_pkg::ST_PUSH && count_reg == 3'h1) begin
      mask_reg <= 1'b1;
    end else if (state_reg == irq_prio_pkg::ST_POP && count_reg == 3'h1) begin
      mask_reg <= i_stacked_mask;
    end else if (i_wr && i_addr == irq_prio_pkg::ADDR_CTRL) begin
      mask_reg <= i_wdata[irq_prio_pkg::CTRL_MASK_BIT];
    end
  end

  // Option bits held in the control register
  always_ff @(posedge i_sys_clk) begin
    if (rst_any) begin
      ctrl_reg <= irq_prio_pkg::CTRL_RESET;
    end else if (i_wr && i_addr == irq_prio_pkg::ADDR_CTRL) begin
      ctrl_reg <= {5'h00, i_wdata[2:0]};
    end
  end

  // Sequencer outputs, all registered
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_abort         <= 1'b0;
      o_stack_push    <= 1'b0;
      o_stack_pop     <= 1'b0;
      o_stack_index   <= 3'h0;
      o_vector_valid  <= 1'b0;
      o_vector_addr   <= irq_prio_pkg::VEC_RESET;
      o_vector_source <= irq_prio_pkg::SRC_NONE;
      o_resume        <= 1'b0;
    end else if (i_reset_req) begin
      o_abort         <= 1'b1;
      o_stack_push    <= 1'b0;
      o_stack_pop     <= 1'b0;
      o_stack_index   <= 3'h0;
      o_vector_valid  <= 1'b1;
      o_vector_addr   <= irq_prio_pkg::VEC_RESET;
      o_vector_source <= irq_prio_pkg::SRC_RESET;
      o_resume        <= 1'b0;
    end else begin
      o_abort        <= 1'b0;
      o_stack_push   <= (state_reg == irq_prio_pkg::ST_PUSH);
      o_stack_pop    <= (state_reg == irq_prio_pkg::ST_POP);
      o_stack_index  <= count_reg;
      o_vector_valid <= (state_reg == irq_prio_pkg::ST_VECTOR);
      if (state_reg == irq_prio_pkg::ST_VECTOR) begin
        o_vector_addr   <= pend_vec_reg;
        o_vector_source <= pend_src_reg;
      end
      o_resume <= (state_reg == irq_prio_pkg::ST_POP) && (count_reg == 3'h1);
    end
  end

  // Mask and line level mirrored on flops for the core's branch tests
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_global_mask <= 1'b1;
      o_line_high   <= 1'b1;
    end else begin
      o_global_mask <= mask_reg;
      o_line_high   <= ext.line_high;
    end
  end

  // Read data valid only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        irq_prio_pkg::ADDR_CTRL: begin
          o_rdata <= {ctrl_reg[7:1], mask_reg};
        end
        irq_prio_pkg::ADDR_STATUS: begin
          o_rdata <= {2'h0, trap_deferred_reg, hw_now[3:1], ext.request, ext.line_high};
        end
        irq_prio_pkg::ADDR_VEC_LO: begin
          o_rdata <= o_vector_addr[7:0];
        end
        irq_prio_pkg::ADDR_VEC_HI: begin
          o_rdata <= o_vector_addr[15:8];
        end
        default: begin
          o_rdata <= 8'h00;
        end
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end

endmodule
`default_nettype wire

//--- verification/cpu_seq_model.sv
// Behavioural instruction sequencer facing the prioritizer
`timescale 1ns/1ps
`default_nettype none
module cpu_seq_model (
  input  wire logic i_sys_clk,
  input  wire logic i_rst,
  input  wire logic i_go,
  input  wire logic i_trap,
  input  wire logic i_ret,
  output logic      o_fetch,
  output logic      o_done,
  output logic      o_is_trap,
  output logic      o_rti
);
  // Fetch, then completion a cycle later, so requests arriving in between stay pending
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_fetch <= 1'b0;
      o_done  <= 1'b0;
      o_rti   <= 1'b0;
    end else begin
      o_fetch <= i_go;
      o_done  <= o_fetch;
      o_rti   <= i_ret;
    end
  end
  // Trap qualifier held as a level from start until the next start
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_is_trap <= 1'b0;
    end else if (i_go) begin
      o_is_trap <= i_trap;
    end
  end
endmodule
`default_nettype wire

//--- verification/mcu_interrupt_prioritizer_sva.sv
// Concurrent checks on the interrupt prioritizer ports
`timescale 1ns/1ps
`default_nettype none
module irq_prio_sva (
  input wire logic        i_sys_clk,
  input wire logic        i_rst,
  input wire logic        i_instr_done,
  input wire logic        i_reset_req,
  input wire logic        o_abort,
  input wire logic        o_stack_push,
  input wire logic        o_stack_pop,
  input wire logic [2:0]  o_stack_index,
  input wire logic        o_vector_valid,
  input wire logic [15:0] o_vector_addr,
  input wire logic [2:0]  o_vector_source,
  input wire logic        o_resume,
  input wire logic        o_global_mask
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  // Vector pair that each source code must point at
  function automatic logic [15:0] pair_of(input logic [2:0] s);
    case (s)
      irq_prio_pkg::SRC_TRAP:  pair_of = irq_prio_pkg::VEC_TRAP;
      irq_prio_pkg::SRC_EXT:   pair_of = irq_prio_pkg::VEC_EXT;
      irq_prio_pkg::SRC_TIMER: pair_of = irq_prio_pkg::VEC_TIMER;
      irq_prio_pkg::SRC_SCI:   pair_of = irq_prio_pkg::VEC_SCI;
      irq_prio_pkg::SRC_SPI:   pair_of = irq_prio_pkg::VEC_SPI;
      default:                 pair_of = irq_prio_pkg::VEC_RESET;
    endcase
  endfunction

  // Stacking only ever starts at an instruction boundary
  chk_push_at_boundary: assert property (
    $rose(o_stack_push) |-> $past(i_instr_done, 2)) else $error("push without boundary");
  chk_push_five: assert property (
    $rose(o_stack_push) |-> o_stack_push[*5] ##1 !o_stack_push) else $error("push length");
  chk_push_index: assert property (
    $rose(o_stack_push) |-> o_stack_index == 3'h5 ##4 o_stack_index == 3'h1)
    else $error("push index order");
  chk_vector_follows: assert property (
    $fell(o_stack_push) |-> o_vector_valid) else $error("no vector after push");
  chk_mask_on_take: assert property (
    o_vector_valid && o_vector_source != irq_prio_pkg::SRC_RESET |=> o_global_mask)
    else $error("mask not set on take");
  // A take that starts while masked can only be the software trap
  chk_masked_trap_only: assert property (
    $rose(o_stack_push) && $past(o_global_mask) |->
      ##5 o_vector_source == irq_prio_pkg::SRC_TRAP) else $error("masked hw taken");
  chk_vector_pair: assert property (
    o_vector_valid |-> o_vector_addr == pair_of(o_vector_source)) else $error("vector pair");
  chk_reset_vector: assert property (
    i_reset_req |=> o_abort && o_vector_valid && o_vector_source == irq_prio_pkg::SRC_RESET)
    else $error("reset vector");
  chk_pop_resume: assert property (
    $rose(o_stack_pop) |-> ##4 (o_resume && o_stack_pop) ##1 !o_stack_pop)
    else $error("return sequence");

  cover property ($rose(o_stack_push));
  cover property (o_resume);
  cover property (o_vector_valid && o_vector_source == irq_prio_pkg::SRC_TRAP);
endmodule

bind mcu_interrupt_prioritizer irq_prio_sva u_sva (
  .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_instr_done(i_instr_done),
  .i_reset_req(i_reset_req), .o_abort(o_abort), .o_stack_push(o_stack_push),
  .o_stack_pop(o_stack_pop), .o_stack_index(o_stack_index),
  .o_vector_valid(o_vector_valid), .o_vector_addr(o_vector_addr),
  .o_vector_source(o_vector_source), .o_resume(o_resume), .o_global_mask(o_global_mask));
`default_nettype wire

//--- verification/mcu_interrupt_prioritizer_tb.sv
// Self-checking bench for the interrupt prioritizer
`timescale 1ns/1ps
`default_nettype none
module mcu_interrupt_prioritizer_tb;
  logic        clk, rst, pin_n, mopt, go, trap, ret, smask, rreq, wr, rd, sen;
  logic        fetch, done, is_trap, return_from_trap_instruction, abort, push, pop, vv, resume, gmask, lh;
  logic [2:0]  tflags, ten, idx, vsrc;
  logic [4:0]  aflags;
  logic [3:0]  aen, addr;
  logic [1:0]  sflags;
  logic [7:0]  pb, pbpu, wdata, rdata;
  logic [15:0] vaddr;
  int          errors, total_checks;

  mcu_interrupt_prioritizer dut (.i_sys_clk(clk), .i_rst(rst), .i_irq_pin_n(pin_n),
    .i_pb_pins(pb), .i_pb_pullup_en(pbpu), .i_mask_option_level(mopt),
    .i_timer_flags(tflags), .i_timer_irq_en(ten), .i_async_flags(aflags),
    .i_async_irq_en(aen), .i_sync_flags(sflags), .i_sync_irq_enable(sen),
    .i_fetch(fetch), .i_instr_done(done), .i_instr_is_trap(is_trap), .i_rti_exec(return_from_trap_instruction),
    .i_stacked_mask(smask), .i_reset_req(rreq), .o_abort(abort), .o_stack_push(push),
    .o_stack_pop(pop), .o_stack_index(idx), .o_vector_valid(vv), .o_vector_addr(vaddr),
    .o_vector_source(vsrc), .o_resume(resume), .o_global_mask(gmask),
    .o_line_high(lh), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata));
  cpu_seq_model cpu (.i_sys_clk(clk), .i_rst(rst), .i_go(go), .i_trap(trap), .i_ret(ret),
    .o_fetch(fetch), .o_done(done), .o_is_trap(is_trap), .o_rti(return_from_trap_instruction));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  function automatic logic [15:0] vec(input logic [2:0] s);
    case (s)
      irq_prio_pkg::SRC_TRAP:  vec = irq_prio_pkg::VEC_TRAP;
      irq_prio_pkg::SRC_EXT:   vec = irq_prio_pkg::VEC_EXT;
      irq_prio_pkg::SRC_TIMER: vec = irq_prio_pkg::VEC_TIMER;
      irq_prio_pkg::SRC_SCI:   vec = irq_prio_pkg::VEC_SCI;
      default:                 vec = irq_prio_pkg::VEC_SPI;
    endcase
  endfunction

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", what, exp, got);
      errors++;
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk("rdata", {8'h00, exp}, {8'h00, rdata});
  endtask

  task automatic instr(input logic t);
    @(posedge clk);
    go <= 1'b1;
    trap <= t;
    @(posedge clk);
    go <= 1'b0;
  endtask

  task automatic pulse_pin();
    @(posedge clk);
    pin_n <= 1'b0;
    repeat (4) @(posedge clk);
    pin_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask

  // Waits a bounded time for the vector, then checks source, pair and mask
  task automatic take(input logic [2:0] src);
    int n;
    n = 0;
    @(negedge clk);
    while (vv !== 1'b1 && n < 16) begin
      @(negedge clk);
      n++;
    end
    chk("valid", 16'h1, {15'h0, vv});
    chk("source", {13'h0, src}, {13'h0, vsrc});
    chk("vector", vec(src), vaddr);
    @(negedge clk);
    chk("mask", 16'h1, {15'h0, gmask});
  endtask

  task automatic no_take(input int n);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      @(negedge clk);
      if (push !== 1'b0) seen = 1'b1;
    end
    chk("no take", 16'h0, {15'h0, seen});
  endtask

  task automatic ret_trap();
    int n;
    @(posedge clk);
    ret <= 1'b1;
    @(posedge clk);
    ret <= 1'b0;
    n = 0;
    while (resume !== 1'b1 && n < 12) begin
      @(negedge clk);
      n++;
    end
    chk("resume", 16'h1, {15'h0, resume});
    @(posedge clk);
  endtask

  task automatic t_reset();
    chk("mask", 16'h1, {15'h0, gmask});
    chk("vector", irq_prio_pkg::VEC_RESET, vaddr);
    reg_rd(irq_prio_pkg::ADDR_CTRL, irq_prio_pkg::CTRL_RESET);
    reg_rd(irq_prio_pkg::ADDR_STATUS, 8'h01);
    reg_rd(irq_prio_pkg::ADDR_VEC_HI, 8'h3F);
    reg_rd(4'hF, 8'h00);
  endtask

  // Timer pending while masked, then unmasked but before a boundary
  task automatic t_mask();
    @(posedge clk);
    tflags <= 3'h1;
    instr(1'b0);
    no_take(10);
    reg_wr(irq_prio_pkg::ADDR_CTRL, 8'h00);
    no_take(4);
    @(posedge clk);
    ten <= 3'h6;
    instr(1'b0);
    no_take(10);
    @(posedge clk);
    ten <= 3'h7;
    instr(1'b0);
    take(irq_prio_pkg::SRC_TIMER);
    @(posedge clk);
    tflags <= 3'h0;
    ret_trap();
  endtask

  // All four sources at once; a second pin pulse during service is kept
  task automatic t_prio();
    logic [2:0] order [5];
    order = '{irq_prio_pkg::SRC_EXT, irq_prio_pkg::SRC_EXT, irq_prio_pkg::SRC_TIMER,
              irq_prio_pkg::SRC_SCI, irq_prio_pkg::SRC_SPI};
    @(posedge clk);
    tflags <= 3'h2;
    aflags <= 5'h04;
    sflags <= 2'h1;
    pulse_pin();
    for (int i = 0; i < 5; i++) begin
      instr(1'b0);
      take(order[i]);
      if (i == 0) pulse_pin();
      @(posedge clk);
      if (i == 2) tflags <= 3'h0;
      if (i == 3) aflags <= 5'h00;
      if (i == 4) sflags <= 2'h0;
      ret_trap();
    end
  endtask

  task automatic t_portb();
    @(posedge clk);
    pbpu <= 8'h04;
    pb <= 8'hDF;
    repeat (6) @(posedge clk);
    chk("line", 16'h1, {15'h0, lh});
    instr(1'b0);
    no_take(10);
    @(posedge clk);
    pb <= 8'hDB;
    repeat (6) @(posedge clk);
    chk("line", 16'h0, {15'h0, lh});
    instr(1'b0);
    take(irq_prio_pkg::SRC_EXT);
    ret_trap();
    instr(1'b0);
    no_take(10);
    reg_wr(irq_prio_pkg::ADDR_CTRL, 8'h02);
    instr(1'b0);
    take(irq_prio_pkg::SRC_EXT);
    @(posedge clk);
    pb <= 8'hFF;
    ret_trap();
  endtask

  // Trap fetched with a timer request already pending comes second
  task automatic t_defer();
    @(posedge clk);
    tflags <= 3'h4;
    instr(1'b1);
    take(irq_prio_pkg::SRC_TIMER);
    @(posedge clk);
    tflags <= 3'h0;
    ret_trap();
    instr(1'b0);
    take(irq_prio_pkg::SRC_TRAP);
    ret_trap();
  endtask

  task automatic t_trap();
    reg_wr(irq_prio_pkg::ADDR_CTRL, 8'h01);
    instr(1'b1);
    take(irq_prio_pkg::SRC_TRAP);
    ret_trap();
  endtask

  task automatic t_rreq();
    @(posedge clk);
    rreq <= 1'b1;
    @(posedge clk);
    rreq <= 1'b0;
    @(negedge clk);
    chk("abort", 16'h1, {15'h0, abort});
    chk("source", 16'h1, {13'h0, vsrc});
    @(negedge clk);
    chk("mask", 16'h1, {15'h0, gmask});
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    stop_test();
  end

  initial begin
    {rst, pin_n} = 2'b11;
    {mopt, go, trap, ret, smask, rreq, wr, rd} = 8'h00;
    {tflags, aflags, sflags} = 10'h000;
    {ten, aen, sen} = 8'hFF;
    {pb, pbpu, addr, wdata} = {8'hFF, 20'h00000};
    errors = 0;
    total_checks = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    t_reset();
    $display("reset test done");
    t_mask();
    $display("mask test done");
    t_prio();
    $display("priority test done");
    t_portb();
    $display("port test done");
    t_defer();
    $display("defer test done");
    t_trap();
    $display("trap test done");
    t_rreq();
    $display("reset request test done");
    stop_test();
  end
endmodule
`default_nettype wire
